// File: ppl_cfg.svh
// Constants for the parameter priority and EEPROM loader
`ifndef PPL_CFG_SVH
`define PPL_CFG_SVH
`define PPL_CAT_W        5
`define PPL_HI_FIRST     5'h0c
`define PPL_HI_LAST      5'h15
`define PPL_HI_EXTRA     5'h17
`define PPL_LO_FIRST     5'h01
`define PPL_LO_LAST      5'h0b
`define PPL_LO_EXTRA_A   5'h16
`define PPL_LO_EXTRA_B   5'h18
`define PPL_CPU_CAT      5'h0c
`define PPL_ID_ADDR0     10'h000
`define PPL_ID_ADDR1     10'h001
`define PPL_DATA_BASE    10'h002
`define PPL_READ_OP      3'h6
`define PPL_CLK_DIV      4'h4
`define PPL_ZERO8        8'h00
`define PPL_ZERO16       16'h0000
`endif

// File: ppl_pkg.sv
// Types for the parameter priority and EEPROM loader
package ppl_pkg;
  typedef enum logic [2:0] {
    PPL_IDLE  = 3'b000,
    PPL_ID0   = 3'b001,
    PPL_ID1   = 3'b010,
    PPL_LOAD  = 3'b011,
    PPL_DONE  = 3'b100
  } ppl_state_t;
endpackage : ppl_pkg

// File: ppl_eeprom_reader.sv
// Serial EEPROM byte reader: one address in, one byte out
`timescale 1ns/100ps
`include "ppl_cfg.svh"
module ppl_eeprom_reader
  import ppl_pkg::*;
#(
  parameter int ADDR_W = 10
)(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Request and answer
  input  wire logic              readStart,
  input  wire logic [ADDR_W-1:0] readAddr,
  output logic                   readDone,
  output logic [7:0]             readData,
  // Serial EEPROM pins
  output logic                   eepromChipSelect,
  output logic                   eepromSerialClock,
  output logic                   eepromSerialOut,
  input  wire logic              eepromSerialIn
);
  typedef struct packed {
    logic              busy;
    logic [3:0]        div;
    logic [5:0]        bitCnt;
    logic [12:0]       shOut;
    logic [7:0]        shIn;
    logic              sck;
    logic              done;
  } ppl_rd_t;
  localparam int NBITS = 3 + ADDR_W + 8;
  ppl_rd_t st_reg, st_next;

  // Op code and address shifted out, then 8 data bits shifted in
  always_comb
  begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy && readStart)
    begin
      st_next.busy   = 1'b1;
      st_next.bitCnt = '0;
      st_next.div    = '0;
      st_next.shOut  = {`PPL_READ_OP, readAddr};
    end
    else if (st_reg.busy)
    begin
      st_next.div = st_reg.div + 4'h1;
      if (st_reg.div == `PPL_CLK_DIV - 4'h1)
      begin
        st_next.div = '0;
        st_next.sck = ~st_reg.sck;
        if (st_reg.sck)
        begin
          // Falling edge: advance to next bit
          st_next.shOut  = {st_reg.shOut[11:0], 1'b0};
          st_next.bitCnt = st_reg.bitCnt + 6'h1;
          if (st_reg.bitCnt == 6'(NBITS - 1))
          begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
          end
        end
        else if (st_reg.bitCnt >= 6'(NBITS - 8))
          st_next.shIn = {st_reg.shIn[6:0], eepromSerialIn};
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign readDone          = st_reg.done;
  assign readData          = st_reg.shIn;
  assign eepromChipSelect  = st_reg.busy;
  assign eepromSerialClock = st_reg.sck;
  assign eepromSerialOut   = st_reg.shOut[12];
endmodule : ppl_eeprom_reader

// File: ppl_param_loader.sv
// Parameter priority arbiter and EEPROM start-up loader
`timescale 1ns/100ps
`include "ppl_cfg.svh"
module ppl_param_loader
  import ppl_pkg::*;
#(
  parameter int           NPARAM    = 16,
  parameter int           ADDR_W    = 10,
  parameter logic [15:0]  ID_VALUE  = 16'h5a3c, // Arbitrary identity value
  parameter logic [7:0]   DEF_VALUE = 8'h00
)(
  // Clock and power-on reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  // Host category write port
  input  wire logic                     catWrite,
  input  wire logic [`PPL_CAT_W-1:0]    catNumber,
  input  wire logic [$clog2(NPARAM)-1:0] catParam,
  input  wire logic [7:0]               catData,
  // Port-switch drive
  input  wire logic [NPARAM-1:0]        portDriveActive,
  input  wire logic [NPARAM*8-1:0]      portDriveValue,
  // Built-in controller update of high class
  input  wire logic                     ctrlWrite,
  input  wire logic [$clog2(NPARAM)-1:0] ctrlParam,
  input  wire logic [7:0]               ctrlData,
  // Parameter and status outputs
  output logic [NPARAM*8-1:0]           paramValue,
  output logic                          controllerHaltFlag,
  output logic                          loadDone,
  output logic                          eepromValid,
  // Serial EEPROM pins
  output logic                          eepromChipSelect,
  output logic                          eepromSerialClock,
  output logic                          eepromSerialOut,
  input  wire logic                     eepromSerialIn
);
  localparam int PW = $clog2(NPARAM);

  typedef struct packed {
    ppl_state_t          state;
    logic                start;
    logic [ADDR_W-1:0]   addr;
    logic [7:0]          idHigh;
    logic [PW-1:0]       idx;
    logic [NPARAM-1:0]   hiSet;
    logic [NPARAM*8-1:0] hiVal;
    logic [NPARAM*8-1:0] loVal;
    logic [NPARAM*8-1:0] outVal;
    logic                halt;
    logic                done;
    logic                valid;
  } ppl_top_t;
  ppl_top_t st_reg, st_next;

  logic       readDone;
  logic [7:0] readData;

  // Category class decode, used for host writes
  function automatic logic isHigh(input logic [`PPL_CAT_W-1:0] c);
    isHigh = (c >= `PPL_HI_FIRST && c <= `PPL_HI_LAST) || c == `PPL_HI_EXTRA;
  endfunction : isHigh

  function automatic logic isLow(input logic [`PPL_CAT_W-1:0] c);
    isLow = (c >= `PPL_LO_FIRST && c <= `PPL_LO_LAST) || c == `PPL_LO_EXTRA_A
            || c == `PPL_LO_EXTRA_B;
  endfunction : isLow

  ////////////////////////////////////////////////////////////////////////////
  // Byte reader for the EEPROM
  ppl_eeprom_reader #(
    .ADDR_W (ADDR_W)
  ) u_reader (
    .ref_clk           (ref_clk),
    .resetn            (resetn),
    .readStart         (st_reg.start),
    .readAddr          (st_reg.addr),
    .readDone          (readDone),
    .readData          (readData),
    .eepromChipSelect  (eepromChipSelect),
    .eepromSerialClock (eepromSerialClock),
    .eepromSerialOut   (eepromSerialOut),
    .eepromSerialIn    (eepromSerialIn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start-up load sequence and parameter writes
  always_comb
  begin
    st_next       = st_reg;
    st_next.start = 1'b0;
    unique case (st_reg.state)
      PPL_IDLE:
      begin
        // Reset release reruns the load
        st_next.state = PPL_ID0;
        st_next.addr  = `PPL_ID_ADDR0;
        st_next.start = 1'b1;
      end
      PPL_ID0:
        if (readDone)
        begin
          st_next.idHigh = readData;
          st_next.state  = PPL_ID1;
          st_next.addr   = `PPL_ID_ADDR1;
          st_next.start  = 1'b1;
        end
      PPL_ID1:
        if (readDone)
        begin
          if ({st_reg.idHigh, readData} == ID_VALUE)
          begin
            // Valid is raised with done after the last byte is stored; paramValue shows that byte a cycle later
            st_next.state = PPL_LOAD;
            st_next.idx   = '0;
            st_next.addr  = `PPL_DATA_BASE;
            st_next.start = 1'b1;
          end
          else
          begin
            // Invalid image: defaults stay in place
            st_next.valid = 1'b0;
            st_next.state = PPL_DONE;
            st_next.done  = 1'b1;
          end
        end
      PPL_LOAD:
        if (readDone)
        begin
          // Stored image lands in the low class; halt flag is bit 0 of its first byte
          st_next.loVal[st_reg.idx*8 +: 8] = readData;
          if (st_reg.idx == '0)
            st_next.halt = readData[0];
          if (st_reg.idx == PW'(NPARAM - 1))
          begin
            st_next.state = PPL_DONE;
            st_next.done  = 1'b1;
            st_next.valid = 1'b1;
          end
          else
          begin
            st_next.idx   = st_reg.idx + 1'b1;
            st_next.addr  = st_reg.addr + 1'b1;
            st_next.start = 1'b1;
          end
        end
      PPL_DONE:
      begin
        // Host writes; the halt flag sits in the CPU category
        if (catWrite && isHigh(catNumber))
        begin
          st_next.hiVal[catParam*8 +: 8] = catData;
          st_next.hiSet[catParam]        = 1'b1;
          if (catNumber == `PPL_CPU_CAT && catParam == '0)
            st_next.halt = catData[0];
        end
        else if (catWrite && isLow(catNumber))
          st_next.loVal[catParam*8 +: 8] = catData;
        // Controller updates only while not halted
        if (ctrlWrite && !st_reg.halt)
        begin
          st_next.hiVal[ctrlParam*8 +: 8] = ctrlData;
          st_next.hiSet[ctrlParam]        = 1'b1;
        end
      end
      default:
        st_next.state = PPL_IDLE;
    endcase
    // Output arbitration, port switches first
    for (int i = 0; i < NPARAM; i++)
    begin
      if (portDriveActive[i])
        st_next.outVal[i*8 +: 8] = portDriveValue[i*8 +: 8];
      else if (st_reg.hiSet[i])
        st_next.outVal[i*8 +: 8] = st_reg.hiVal[i*8 +: 8];
      else
        st_next.outVal[i*8 +: 8] = st_reg.loVal[i*8 +: 8];
    end
    // Writes to a port-driven parameter are dropped
    for (int i = 0; i < NPARAM; i++)
    begin
      if (portDriveActive[i])
      begin
        st_next.hiVal[i*8 +: 8] = st_reg.hiVal[i*8 +: 8];
        st_next.loVal[i*8 +: 8] = st_reg.loVal[i*8 +: 8];
        st_next.hiSet[i]        = st_reg.hiSet[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; defaults loaded by reset
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg        <= '0;
      st_reg.loVal  <= {NPARAM{DEF_VALUE}};
      st_reg.outVal <= {NPARAM{DEF_VALUE}};
    end
    else
      st_reg <= st_next;
  end

  assign paramValue         = st_reg.outVal;
  assign controllerHaltFlag = st_reg.halt;
  assign loadDone           = st_reg.done;
  assign eepromValid        = st_reg.valid;
endmodule : ppl_param_loader

// File: ppl_param_loader_checker.sv
// Port-level assertions for the parameter priority loader
`timescale 1ns/100ps
`include "ppl_cfg.svh"
module ppl_param_loader_checker #(
  parameter int NPARAM = 16
)(
  // Clock, reset, host and controller writes
  input wire logic                        ref_clk, resetn, catWrite, ctrlWrite,
  input wire logic [`PPL_CAT_W-1:0]       catNumber,
  input wire logic [$clog2(NPARAM)-1:0]   catParam, ctrlParam,
  input wire logic [7:0]                  catData, ctrlData,
  // Port-switch drive and parameter outputs
  input wire logic [NPARAM-1:0]           portDriveActive,
  input wire logic [NPARAM*8-1:0]         portDriveValue, paramValue,
  // Status and EEPROM pins
  input wire logic                        controllerHaltFlag, loadDone, eepromValid,
  input wire logic                        eepromChipSelect, eepromSerialClock,
  input wire logic                        eepromSerialOut, eepromSerialIn
);
  localparam int TOP = NPARAM*8-1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Captured value compared two cycles on, the stored-then-arbitrated latency
  property p_lands(bit c, logic [$clog2(NPARAM)-1:0] q, logic [7:0] v);
    logic [$clog2(NPARAM)-1:0] p;
    logic [7:0] d;
    (c, p = q, d = v) |-> ##2 paramValue[p*8 +: 8] == d;
  endproperty
  a_port_wins: assert property ($past(resetn) && $past(portDriveActive[NPARAM-1])
    |-> paramValue[TOP -: 8] == $past(portDriveValue[TOP -: 8])) else $error("port value lost");
  a_high_lands: assert property (p_lands(catWrite && loadDone && !portDriveActive[catParam]
    && catNumber inside {[5'h0c:5'h15], 5'h17}, catParam, catData)) else $error("high write lost");
  a_bad_cat: assert property (p_lands(catWrite && loadDone && (catNumber == 5'h00
    || catNumber > 5'h18), catParam, paramValue[catParam*8 +: 8])) else $error("bad category used");
  a_halt_holds: assert property (p_lands(ctrlWrite && loadDone && controllerHaltFlag,
    ctrlParam, paramValue[ctrlParam*8 +: 8])) else $error("halted controller wrote");
  a_done_sticky: assert property (loadDone |=> loadDone) else $error("done dropped");
  a_valid_done: assert property (eepromValid |-> loadDone) else $error("valid early");
  a_cs_quiet: assert property (loadDone |-> !eepromChipSelect) else $error("read after done");
  a_reset_reads: assert property ($rose(resetn) |-> ##[0:8] eepromChipSelect)
    else $error("no read after reset");
  c_valid: cover property (loadDone && eepromValid);
  c_blank: cover property (loadDone && !eepromValid);
  c_halt: cover property (loadDone && controllerHaltFlag);
endmodule : ppl_param_loader_checker

bind ppl_param_loader ppl_param_loader_checker #(.NPARAM(NPARAM)) i_ppl_param_loader_checker (
  .ref_clk(ref_clk), .resetn(resetn), .catWrite(catWrite), .ctrlWrite(ctrlWrite),
  .catNumber(catNumber), .catParam(catParam), .ctrlParam(ctrlParam), .catData(catData),
  .ctrlData(ctrlData), .portDriveActive(portDriveActive), .portDriveValue(portDriveValue),
  .paramValue(paramValue), .controllerHaltFlag(controllerHaltFlag), .loadDone(loadDone),
  .eepromValid(eepromValid), .eepromChipSelect(eepromChipSelect),
  .eepromSerialClock(eepromSerialClock), .eepromSerialOut(eepromSerialOut),
  .eepromSerialIn(eepromSerialIn));

// File: ppl_eeprom_model.sv
// Behavioural serial EEPROM answering single-byte reads
`timescale 1ns/100ps
module ppl_eeprom_model (
  // Pins seen from the memory
  input  wire logic eepromChipSelect,
  input  wire logic eepromSerialClock,
  input  wire logic eepromSerialOut,
  output logic      eepromSerialIn
);
  logic [7:0]  mem [0:1023];
  logic [12:0] cmd;
  logic [7:0]  sh;
  int          n;
  ////////////////////////////////////////////////////////////////////////////////
  // Blank part reads all ones, so an unwritten identity never matches
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    eepromSerialIn = 1'b0;
  end
  always @(posedge eepromChipSelect) n = 0;
  // Opcode and address shift in on rising clock; a wrong opcode gets junk
  always @(posedge eepromSerialClock)
    if (eepromChipSelect)
    begin
      if (n < 13) cmd = {cmd[11:0], eepromSerialOut};
      n = n + 1;
      if (n == 13) sh = (cmd[12:10] == 3'h6) ? mem[cmd[9:0]] : ~mem[cmd[9:0]];
    end
  // Data leaves on falling clock, ready for the next rising sample
  always @(negedge eepromSerialClock)
    if (eepromChipSelect && n >= 13)
    begin
      eepromSerialIn = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  // Released line flips so a stale bit never reads as good
  always @(negedge eepromChipSelect) eepromSerialIn = ~eepromSerialIn;
endmodule : ppl_eeprom_model

// File: tb_top.sv
// Self-checking bench for the parameter priority loader
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        ref_clk, resetn, catWrite, ctrlWrite, controllerHaltFlag, loadDone, eepromValid;
  logic [4:0]  catNumber;
  logic [1:0]  catParam, ctrlParam;
  logic [7:0]  catData, ctrlData, expV;
  logic [3:0]  portDriveActive;
  logic [31:0] portDriveValue, paramValue;
  logic        cs, sck, sdo, sdi, hiCat, seenHi;
  int          miscompares, n_compared, cyc;
  ppl_param_loader #(.NPARAM(4)) i_ppl_param_loader (.ref_clk(ref_clk), .resetn(resetn),
    .catWrite(catWrite), .catNumber(catNumber), .catParam(catParam), .catData(catData),
    .portDriveActive(portDriveActive), .portDriveValue(portDriveValue), .ctrlWrite(ctrlWrite),
    .ctrlParam(ctrlParam), .ctrlData(ctrlData), .paramValue(paramValue),
    .controllerHaltFlag(controllerHaltFlag), .loadDone(loadDone), .eepromValid(eepromValid),
    .eepromChipSelect(cs), .eepromSerialClock(sck), .eepromSerialOut(sdo), .eepromSerialIn(sdi));
  ppl_eeprom_model i_ppl_eeprom_model (.eepromChipSelect(cs), .eepromSerialClock(sck),
    .eepromSerialOut(sdo), .eepromSerialIn(sdi));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Power-on reset, then wait for the start-up load
  task automatic boot();
    int k;
    k = 0;
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    while (loadDone !== 1'b1 && k < 5000)
    begin
      @(negedge ref_clk);
      k++;
    end
    // Last image byte reaches the outputs one cycle after done
    repeat (2) @(negedge ref_clk);
  endtask : boot
  // One-cycle host or controller write, then the two-cycle landing
  task automatic wr(input logic [4:0] c, input logic [1:0] p, input logic [7:0] d, input bit ctl);
    @(negedge ref_clk);
    {catWrite, ctrlWrite} = {!ctl, ctl};
    {catNumber, catParam, ctrlParam, catData, ctrlData} = {c, p, p, d, d};
    @(negedge ref_clk);
    {catWrite, ctrlWrite} = 2'b00;
    repeat (2) @(negedge ref_clk);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    {resetn, catWrite, ctrlWrite, catNumber, catParam, catData, ctrlParam, ctrlData} = '0;
    {portDriveActive, portDriveValue, seenHi, expV} = '0;
    boot();
    `CHK("valid", 1'b0, eepromValid)
    `CHK("defaults", 32'h0, paramValue)
    `CHK("cs idle", 1'b0, cs)
    wr(5'h00, 2'h1, 8'h5e, 1'b1);
    `CHK("ctrl", 8'h5e, paramValue[15:8])
    wr(5'h00, 2'h1, 8'h11, 1'b0);
    wr(5'h19, 2'h1, 8'h12, 1'b0);
    `CHK("badcat", 8'h5e, paramValue[15:8])
    // Every category once; low ones after a high one must lose
    for (int c = 1; c <= 24; c++)
    begin
      hiCat = (c >= 12 && c <= 21) || c == 23;
      if (!hiCat) wr(5'(c), 2'h0, 8'(c), 1'b0);
      if (!hiCat) `CHK("low", 8'(c), paramValue[7:0])
      wr(5'(c), 2'h2, 8'(8'h40 + c), 1'b0);
      if (hiCat || !seenHi) expV = 8'(8'h40 + c);
      seenHi |= hiCat;
      `CHK("prio", expV, paramValue[23:16])
    end
    portDriveActive = 4'h8;
    portDriveValue = 32'ha500_0000;
    wr(5'h0e, 2'h3, 8'h01, 1'b0);
    wr(5'h02, 2'h3, 8'h02, 1'b0);
    `CHK("port", 8'ha5, paramValue[31:24])
    portDriveActive = 4'h0;
    // Host image with halt set, identity first
    {i_ppl_eeprom_model.mem[0], i_ppl_eeprom_model.mem[1]} = 16'h5a3c;
    {i_ppl_eeprom_model.mem[2], i_ppl_eeprom_model.mem[3]} = 16'h0122;
    {i_ppl_eeprom_model.mem[4], i_ppl_eeprom_model.mem[5]} = 16'h3344;
    `CHK("verify", 8'h5a, i_ppl_eeprom_model.mem[0])
    boot();
    `CHK("valid", 1'b1, eepromValid)
    `CHK("image", 32'h4433_2201, paramValue)
    `CHK("halt", 1'b1, controllerHaltFlag)
    wr(5'h00, 2'h1, 8'h77, 1'b1);
    `CHK("held", 8'h22, paramValue[15:8])
    // Reset cut into a running load must restart it cleanly
    resetn = 1'b0;
    @(negedge ref_clk);
    resetn = 1'b1;
    repeat (300) @(negedge ref_clk);
    boot();
    `CHK("reload", 32'h4433_2201, paramValue)
    i_ppl_eeprom_model.mem[2] = 8'h00;
    boot();
    `CHK("run", 1'b0, controllerHaltFlag)
    wr(5'h00, 2'h1, 8'h77, 1'b1);
    `CHK("ctrl2", 8'h77, paramValue[15:8])
    tally_and_finish();
  end
endmodule : tb_top
